// >>> rxbfc_card_model.sv
`timescale 1ns/100ps
module rxbfc_card_model
	import rxbfc_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Decoder side
	output rxbfc_rx_bit_t rx_bit_o,
	output rxbfc_rx_evt_t rx_evt_o
);
	initial begin
		rx_bit_o = '0;
		rx_evt_o = '0;
	end
	// ==========================================================
	// Frame sender; gap inserts idle cycles, data flips so stale bits never look fresh
	task automatic send(input int n, input int c, input logic [79:0] b, input logic ie,
		input int gap);
		rx_evt_o <= 3'h4;
		@(posedge clk_i);
		rx_evt_o <= '0;
		for (int k = 0; k < n; k++) begin
			rx_bit_o <= {1'h1, b[k], k == c};
			@(posedge clk_i);
			repeat (gap) begin
				rx_bit_o <= {1'h0, ~b[k], 1'h0};
				@(posedge clk_i);
			end
		end
		rx_bit_o <= {1'h0, ~rx_bit_o.data, 1'h0};
		rx_evt_o <= {2'h1, ie};
		@(posedge clk_i);
		rx_evt_o <= '0;
	endtask : send
endmodule : rxbfc_card_model

// >>> rxbfc_pkg.sv
package rxbfc_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] RXBFC_IDX_ERROR = 6'h0a;
	localparam logic [5:0] RXBFC_IDX_LINK_STATUS = 6'h0b;
	localparam logic [5:0] RXBFC_IDX_RX_BIT_CTRL = 6'h0c;
	localparam logic [5:0] RXBFC_IDX_RX_COLL_POS = 6'h0d;
	localparam logic [5:0] RXBFC_IDX_IRQ_STATUS = 6'h10;
	localparam logic [5:0] RXBFC_IDX_IRQ_MASK = 6'h11;

	// ==========================================================
	// Field positions
	localparam int RXBFC_ERR_COLL_BIT = 2;
	localparam int RXBFC_ERR_INTEG_BIT = 0;
	localparam int RXBFC_ST_CIPHER_BIT = 5;
	localparam int RXBFC_CTL_KEEP_BIT = 7;
	localparam int RXBFC_CTL_ALIGN_LSB = 4;
	localparam int RXBFC_CTL_COLLISION_AS_INTEGRITY_ERROR_BIT = 3;
	localparam int RXBFC_COLL_VALID_BIT = 7;
	localparam int RXBFC_IRQ_FRAME_BIT = 0;
	localparam int RXBFC_IRQ_COLL_BIT = 1;
	localparam int RXBFC_IRQ_INTEG_BIT = 2;
	localparam int RXBFC_IRQ_WIDTH = 3;

	// ==========================================================
	// Reset values and limits
	localparam logic [4:0] RXBFC_CTL_RESET = 5'h00;
	localparam logic [2:0] RXBFC_IRQ_MASK_RESET = 3'h0;
	localparam logic [6:0] RXBFC_COLL_POS_MAX = 7'h3f;
	localparam logic [2:0] RXBFC_LAST_BITS_RESET = 3'h0;

	// ==========================================================
	// Transceiver state and its status codes
	typedef enum logic [2:0] {
		RXBFC_LS_IDLE,
		RXBFC_LS_TX_WAIT,
		RXBFC_LS_TRANSMITTING,
		RXBFC_LS_RX_WAIT,
		RXBFC_LS_WAIT_DATA,
		RXBFC_LS_RECEIVING
	} rxbfc_link_state_t;

	localparam logic [2:0] RXBFC_CODE_IDLE = 3'h0;
	localparam logic [2:0] RXBFC_CODE_TX_WAIT = 3'h1;
	localparam logic [2:0] RXBFC_CODE_TRANSMITTING = 3'h3;
	localparam logic [2:0] RXBFC_CODE_RX_WAIT = 3'h5;
	localparam logic [2:0] RXBFC_CODE_WAIT_DATA = 3'h6;
	localparam logic [2:0] RXBFC_CODE_RECEIVING = 3'h7;

	// ==========================================================
	// Decoder carriers
	typedef struct packed {
		logic valid;
		logic data;
		logic coll;
	} rxbfc_rx_bit_t;

	typedef struct packed {
		logic start;
		logic done;
		logic integ_err;
	} rxbfc_rx_evt_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} rxbfc_rx_byte_t;

endpackage : rxbfc_pkg

// >>> rxbfc_properties.sv
`timescale 1ns/100ps
module rxbfc_props
	import rxbfc_pkg::*;
#(
	parameter int ADR_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Link and decoder
	input wire rxbfc_link_state_t link_fsm_state_i,
	input wire logic card_auth_done_i,
	input wire logic cipher_active_o,
	input wire rxbfc_rx_bit_t rx_bit_i,
	input wire rxbfc_rx_evt_t rx_evt_i,
	input wire rxbfc_rx_byte_t rx_byte_o,
	input wire logic irq_o
);
	// ==========================================================
	// Helpers
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	localparam logic [2:0] CD [6] = '{RXBFC_CODE_IDLE, RXBFC_CODE_TX_WAIT,
		RXBFC_CODE_TRANSMITTING, RXBFC_CODE_RX_WAIT, RXBFC_CODE_WAIT_DATA, RXBFC_CODE_RECEIVING};
	wire rd_ack = cyc_i && stb_i && ack_o && !we_i;
	wire st_sel = adr_i[7:2] == RXBFC_IDX_LINK_STATUS;

	// ==========================================================
	// Assertions
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	cipher_auth_a: assert property (card_auth_done_i |=> cipher_active_o)
		else $error("cipher not set");
	cipher_hold_a: assert property (!cipher_active_o && !card_auth_done_i
		|=> !cipher_active_o) else $error("cipher set wrongly");
	cipher_clear_a: assert property (cyc_i && stb_i && we_i && ack_o && st_sel && sel_i[0]
		&& !dat_i[5] && !card_auth_done_i |=> !cipher_active_o) else $error("cipher kept");
	state_code_a: assert property (rd_ack && st_sel
		|-> dat_o[2:0] == CD[$past(link_fsm_state_i)]) else $error("state code");
	cipher_read_a: assert property (rd_ack && st_sel
		|-> dat_o[5] == $past(cipher_active_o)) else $error("cipher read");
	reserved_zero_a: assert property (rd_ack && st_sel
		|-> dat_o[7:6] == 0 && dat_o[4:3] == 0) else $error("reserved bits");
	coll_range_a: assert property (rd_ack && adr_i[7:2] == RXBFC_IDX_RX_COLL_POS
		|-> !dat_o[7] || dat_o[6:0] <= RXBFC_COLL_POS_MAX) else $error("coll range");
	byte_cause_a: assert property (rx_byte_o.valid
		|-> $past(rx_bit_i.valid) || $past(rx_evt_i.done)) else $error("stray byte");
	cover property (rx_byte_o.valid && rx_byte_o.last);
	cover property (card_auth_done_i ##1 cipher_active_o);
	cover property ($rose(irq_o));
endmodule : rxbfc_props

bind rxbfc_top rxbfc_props #(.ADR_W(ADR_W)) i_rxbfc_props (.*);

// >>> rxbfc_tb_top.sv
`timescale 1ns/100ps
module rxbfc_tb_top;
	import rxbfc_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, card_auth_done_i = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o, cipher_active_o, irq_o;
	rxbfc_link_state_t link_fsm_state_i = RXBFC_LS_IDLE;
	rxbfc_rx_bit_t rx_bit_i;
	rxbfc_rx_evt_t rx_evt_i;
	rxbfc_rx_byte_t rx_byte_o;
	int fail_count = 0, samples_checked = 0, seed = 11628, last_seen = 0;
	logic [7:0] got[$], exp[$];
	logic [95:0] bits;
	logic [7:0] ra[5] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c};
	logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};

	always #10 clk_i = ~clk_i;
	rxbfc_top i_rxbfc_top (.*);
	rxbfc_card_model i_rxbfc_card_model (.clk_i(clk_i), .rx_bit_o(rx_bit_i), .rx_evt_o(rx_evt_i));
	always @(posedge clk_i) if (rx_byte_o.valid === 1'h1) got.push_back(rx_byte_o.data);
	always @(posedge clk_i) if (rx_byte_o.last === 1'h1) last_seen++;

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", what, want, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h1;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		cyc_i <= 1'h0; stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [31:0] want, input string what);
		wb(1'h0, a, 32'h0);
		chk(rd, want, what);
	endtask : rchk
	// Reference frame: bits land from first_bit_pos upward, zeroed after collision unless kp is set
	task automatic frame(input int al, n, c, input logic kp, nc, ie);
		int k, pos;
		logic [7:0] b;
		b = 8'h00;
		bits = {$random(seed), $random(seed), $random(seed)};
		wb(1'h1, 8'h30, {24'h0, kp, al[2:0], nc, 3'h0});
		got.delete();
		exp.delete();
		last_seen = 0;
		for (int p = 0; p < al + n; p++) begin
			k = p - al;
			b[p % 8] = (k < 0 || (!kp && c >= 0 && k > c)) ? 1'h0 : bits[k];
			if (p % 8 == 7) begin
				exp.push_back(b);
				b = 8'h00;
			end
		end
		if ((al + n) % 8 != 0) exp.push_back(b);
		i_rxbfc_card_model.send(n, c, bits[79:0], ie, al % 2);
		repeat (3) @(posedge clk_i);
		chk(got.size(), exp.size(), "byte count");
		foreach (exp[i]) chk(got[i], exp[i], "byte");
		chk(last_seen, 1, "frame end");
		rchk(8'h30, {24'h0, kp, al[2:0], nc, 3'((al + n) % 8)}, "ctl");
		pos = al + c;
		// Out of range only the low six bits of the index stay, flag clear
		pos = (c < 0) ? 0 : (pos < 64) ? 32'h80 | pos : pos % 64;
		rchk(8'h34, pos, "coll");
		rchk(8'h28, {29'h0, c >= 0, 1'h0, (c >= 0 && nc) || ie}, "error");
	endtask : frame

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		foreach (ra[i]) rchk(ra[i], 32'h0, "reset value");
		for (int i = 0; i < 6; i++) begin
			link_fsm_state_i <= rxbfc_link_state_t'(i);
			rchk(8'h2c, {29'h0, cd[i]}, "state");
		end
		wb(1'h1, 8'h2c, 32'hff);
		chk(cipher_active_o, 1'h0, "cipher write one");
		card_auth_done_i <= 1'h1;
		@(posedge clk_i);
		card_auth_done_i <= 1'h0;
		@(posedge clk_i);
		rchk(8'h2c, 32'h27, "cipher on");
		wb(1'h1, 8'h2c, 32'h0);
		chk(cipher_active_o, 1'h0, "cipher off");
		frame(0, 16, -1, 1'h0, 1'h0, 1'h0);
		frame(4, 4, 3, 1'h0, 1'h0, 1'h0);
		frame(7, 9, 0, 1'h0, 1'h1, 1'h0);
		frame(0, 12, 8, 1'h0, 1'h0, 1'h1);
		frame(1, 70, 66, 1'h1, 1'h0, 1'h0);
		chk(irq_o, 1'h0, "irq masked");
		rchk(8'h40, 32'h7, "irq status");
		wb(1'h1, 8'h44, 32'h7);
		chk(irq_o, 1'h1, "irq on");
		wb(1'h1, 8'h40, 32'h7);
		chk(irq_o, 1'h0, "irq cleared");
		rchk(8'h40, 32'h0, "irq status clear");
		report_and_stop;
	end
	// Run is about 340 cycles; the limit leaves wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		report_and_stop;
	end
endmodule : rxbfc_tb_top

// >>> rxbfc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Status bit 5 shows cipher engaged; host writing zero turns it off at once unless card authentication completes in that same cycle.
// - Cipher flag sets only when card authentication completes; writing one does nothing.
// - Three-bit link state uses codes 0,1,3,5,6,7; code 4 never appears.
// - With keep-bits control clear, bits after a collision are stored as zero.
// - First-bit-position picks where first bit lands; later bits go upward.
// - Position seven puts first bit at bit 7, second at bit 0 next byte.
// - Position zero means byte-oriented reception, nonzero means bit-oriented.
// - With collision-as-integrity control set, a collision raises integrity error.
// - Last-valid-bits gives valid bits of final byte; zero means all eight.
// - Decoder writes last-valid-bits at frame end and clears it at reception start.
// - Position-valid flag is one only when the stored collision position is valid.
// - Collision position is zero-based index of first collided data bit.
// - Positions reportable only within first eight bytes, max 3Fh, else invalid.
// - Reported position includes first-bit-position offset, counting from stored bit zero.
// - A collision sets collision-detected and records the first collision position.
// - Parity or CRC error sets integrity error; reception carries on.
module rxbfc_top
	import rxbfc_pkg::*;
#(
	parameter int ADR_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Transceiver and cipher
	input wire rxbfc_link_state_t link_fsm_state_i,
	input wire logic card_auth_done_i,
	output logic cipher_active_o,
	// Receive decoder
	input wire rxbfc_rx_bit_t rx_bit_i,
	input wire rxbfc_rx_evt_t rx_evt_i,
	output rxbfc_rx_byte_t rx_byte_o,
	// Interrupt
	output logic irq_o
);

	// ==========================================================
	// Helpers
	function automatic logic [2:0] state_code(input rxbfc_link_state_t s);
		case (s)
			RXBFC_LS_IDLE: state_code = RXBFC_CODE_IDLE;
			RXBFC_LS_TX_WAIT: state_code = RXBFC_CODE_TX_WAIT;
			RXBFC_LS_TRANSMITTING: state_code = RXBFC_CODE_TRANSMITTING;
			RXBFC_LS_RX_WAIT: state_code = RXBFC_CODE_RX_WAIT;
			RXBFC_LS_WAIT_DATA: state_code = RXBFC_CODE_WAIT_DATA;
			RXBFC_LS_RECEIVING: state_code = RXBFC_CODE_RECEIVING;
			// Unknown encodings fall back to idle so 100b can never show
			default: state_code = RXBFC_CODE_IDLE;
		endcase
	endfunction : state_code

	function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] p,
		input logic v);
		logic [7:0] r;
		r = b;
		r[p] = v;
		put_bit = r;
	endfunction : put_bit

	// ==========================================================
	// Bus decode
	logic ack_reg;
	logic [5:0] idx;
	logic wr_commit;
	logic [7:0] wbyte;

	assign idx = adr_i[7:2];
	assign wbyte = dat_i[7:0];
	// Writes land on the same edge the master samples ack
	assign wr_commit = cyc_i & stb_i & we_i & ack_reg & sel_i[0];
	assign ack_o = ack_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			// Every index answers, so a stray access can never hang the master
			ack_reg <= cyc_i & stb_i & ~ack_reg;
		end
	end

	function automatic logic wr_to(input logic c, input logic [5:0] i, input logic [5:0] t);
		wr_to = c & (i == t);
	endfunction : wr_to

	// ==========================================================
	// Control register
	logic keep_bits_after_collision_reg;
	logic [2:0] rx_first_bit_pos_reg;
	logic collision_as_integrity_error_reg;
	logic [2:0] rx_last_valid_bits_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{keep_bits_after_collision_reg, rx_first_bit_pos_reg,
				collision_as_integrity_error_reg} <= RXBFC_CTL_RESET;
		end else if (wr_to(wr_commit, idx, RXBFC_IDX_RX_BIT_CTRL)) begin
			keep_bits_after_collision_reg <= wbyte[RXBFC_CTL_KEEP_BIT];
			rx_first_bit_pos_reg <= wbyte[RXBFC_CTL_ALIGN_LSB +: 3];
			collision_as_integrity_error_reg <= wbyte[RXBFC_CTL_COLLISION_AS_INTEGRITY_ERROR_BIT];
		end
	end

	// ==========================================================
	// Cipher flag
	logic cipher_active_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cipher_active_reg <= 1'b0;
		end else if (card_auth_done_i) begin
			cipher_active_reg <= 1'b1;
		end else if (wr_to(wr_commit, idx, RXBFC_IDX_LINK_STATUS) &&
			!wbyte[RXBFC_ST_CIPHER_BIT]) begin
			cipher_active_reg <= 1'b0;
		end
	end
	assign cipher_active_o = cipher_active_reg;

	// ==========================================================
	// Bit assembly
	logic in_frame_reg;
	logic [2:0] bit_ptr_reg;
	logic [3:0] byte_cnt_reg;
	logic [7:0] shift_reg;
	logic coll_seen_reg;
	logic stored_bit;
	logic [7:0] shift_next;
	logic bit_ok;
	logic frame_end;
	logic byte_full;

	// Start outranks a bit or an end marker in the same cycle
	assign bit_ok = in_frame_reg & rx_bit_i.valid & ~rx_evt_i.start;
	assign frame_end = in_frame_reg & rx_evt_i.done & ~rx_evt_i.start & ~rx_bit_i.valid;
	assign byte_full = bit_ok & (bit_ptr_reg == 3'h7);
	assign stored_bit = (coll_seen_reg & ~keep_bits_after_collision_reg) ? 1'b0 : rx_bit_i.data;
	assign shift_next = put_bit(shift_reg, bit_ptr_reg, stored_bit);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_frame_reg <= 1'b0;
		end else if (rx_evt_i.start) begin
			in_frame_reg <= 1'b1;
		end else if (frame_end) begin
			in_frame_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_ptr_reg <= 3'h0;
		// Nonzero start position gives bit-oriented frame
		end else if (rx_evt_i.start) begin
			bit_ptr_reg <= rx_first_bit_pos_reg;
		end else if (bit_ok) begin
			// Wrap from bit 7 to bit 0 of the next byte
			bit_ptr_reg <= bit_ptr_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byte_cnt_reg <= 4'h0;
		end else if (rx_evt_i.start) begin
			byte_cnt_reg <= 4'h0;
		// Saturates so a long frame never wraps back into the valid range
		end else if (byte_full && byte_cnt_reg != 4'hf) begin
			byte_cnt_reg <= byte_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg <= 8'h00;
		end else if (rx_evt_i.start || byte_full) begin
			shift_reg <= 8'h00;
		end else if (bit_ok) begin
			shift_reg <= shift_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coll_seen_reg <= 1'b0;
		end else if (rx_evt_i.start) begin
			coll_seen_reg <= 1'b0;
		end else if (bit_ok && rx_bit_i.coll) begin
			coll_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_byte_o <= '0;
		end else begin
			rx_byte_o.valid <= byte_full | (frame_end & (bit_ptr_reg != 3'h0));
			rx_byte_o.last <= frame_end;
			if (byte_full) begin
				rx_byte_o.data <= shift_next;
			// A trailing partial byte goes out with the end marker
			end else if (frame_end) begin
				rx_byte_o.data <= shift_reg;
			end
		end
	end

	// ==========================================================
	// Last valid bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_last_valid_bits_reg <= RXBFC_LAST_BITS_RESET;
		// Cleared at start, written at end
		end else if (rx_evt_i.start) begin
			rx_last_valid_bits_reg <= RXBFC_LAST_BITS_RESET;
		end else if (frame_end) begin
			// Zero when the final byte is complete
			rx_last_valid_bits_reg <= bit_ptr_reg;
		// Host may preset it; the decoder overwrites it at the next frame end
		end else if (wr_to(wr_commit, idx, RXBFC_IDX_RX_BIT_CTRL)) begin
			rx_last_valid_bits_reg <= wbyte[2:0];
		end
	end

	// ==========================================================
	// Collision capture and error flags
	logic collision_pos_valid_reg;
	logic [6:0] collision_bit_pos_reg;
	logic collision_detected_reg;
	logic integrity_error_reg;
	logic first_coll;
	logic integ_evt;

	assign first_coll = bit_ok & rx_bit_i.coll & ~coll_seen_reg;
	// Collision counts as integrity error when enabled
	// Parity or CRC error flags and reception goes on
	assign integ_evt = (in_frame_reg & rx_evt_i.integ_err) |
		(bit_ok & rx_bit_i.coll & collision_as_integrity_error_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			collision_bit_pos_reg <= 7'h00;
		end else if (rx_evt_i.start) begin
			collision_bit_pos_reg <= 7'h00;
		end else if (first_coll) begin
			// Index includes the start offset
			// Past the eighth byte only the low six bits remain; the flag tells
			collision_bit_pos_reg <= {byte_cnt_reg[2:0], bit_ptr_reg} & RXBFC_COLL_POS_MAX;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			collision_pos_valid_reg <= 1'b0;
		end else if (rx_evt_i.start) begin
			collision_pos_valid_reg <= 1'b0;
		end else if (first_coll) begin
			// Only the first eight bytes are valid
			collision_pos_valid_reg <= (byte_cnt_reg < 4'h8);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			collision_detected_reg <= 1'b0;
		// Set wins over the start clear
		end else if (first_coll) begin
			collision_detected_reg <= 1'b1;
		end else if (rx_evt_i.start) begin
			collision_detected_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			integrity_error_reg <= 1'b0;
		end else if (integ_evt) begin
			integrity_error_reg <= 1'b1;
		end else if (rx_evt_i.start) begin
			integrity_error_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupts
	logic [RXBFC_IRQ_WIDTH-1:0] irq_status_reg;
	logic [RXBFC_IRQ_WIDTH-1:0] irq_mask_reg;
	logic [RXBFC_IRQ_WIDTH-1:0] irq_set;
	logic [RXBFC_IRQ_WIDTH-1:0] irq_clr;

	always_comb begin
		irq_set = '0;
		irq_set[RXBFC_IRQ_FRAME_BIT] = frame_end;
		irq_set[RXBFC_IRQ_COLL_BIT] = first_coll;
		irq_set[RXBFC_IRQ_INTEG_BIT] = integ_evt;
	end
	assign irq_clr = wr_to(wr_commit, idx, RXBFC_IDX_IRQ_STATUS) ?
		wbyte[RXBFC_IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_reg <= '0;
		end else begin
			// Set wins over a write-one clear in the same cycle
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= RXBFC_IRQ_MASK_RESET;
		end else if (wr_to(wr_commit, idx, RXBFC_IDX_IRQ_MASK)) begin
			irq_mask_reg <= wbyte[RXBFC_IRQ_WIDTH-1:0];
		end
	end

	// Level output; it drops as soon as the cause is cleared or masked
	assign irq_o = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// Read mux
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			RXBFC_IDX_ERROR: begin
				rd_byte[RXBFC_ERR_COLL_BIT] = collision_detected_reg;
				rd_byte[RXBFC_ERR_INTEG_BIT] = integrity_error_reg;
			end
			RXBFC_IDX_LINK_STATUS: begin
				rd_byte[RXBFC_ST_CIPHER_BIT] = cipher_active_reg;
				rd_byte[2:0] = state_code(link_fsm_state_i);
			end
			RXBFC_IDX_RX_BIT_CTRL: begin
				rd_byte = {keep_bits_after_collision_reg, rx_first_bit_pos_reg,
					collision_as_integrity_error_reg, rx_last_valid_bits_reg};
			end
			RXBFC_IDX_RX_COLL_POS: begin
				rd_byte = {collision_pos_valid_reg, collision_bit_pos_reg};
			end
			RXBFC_IDX_IRQ_STATUS: rd_byte[RXBFC_IRQ_WIDTH-1:0] = irq_status_reg;
			RXBFC_IDX_IRQ_MASK: rd_byte[RXBFC_IRQ_WIDTH-1:0] = irq_mask_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (cyc_i && stb_i && !ack_reg) begin
			dat_o <= {24'h000000, rd_byte};
		end
	end

endmodule : rxbfc_top
